// ### core/t16ba_dev.sv
// Timer end: byte access path, shared high-byte holder and counter core
// Behaviour
// RULE1: 16-bit values move as two byte accesses
// RULE2: one shared 8-bit high-byte holding register
// RULE3: low-byte write loads whole word at once
// RULE4: low-byte read copies high byte to holder
// RULE5: compare high reads bypass the holder
// RULE6: host writes high first, reads low first
// RULE7: host keeps two-byte accesses uninterrupted
// RULE8: held high byte reused until overwritten
// RULE9: clock select picks source, zero stops
// RULE10: counter high location reaches the holder
// RULE11: counter clears, increments or decrements per tick
// RULE12: counter accessible with or without ticks
// RULE13: host counter write beats counting
// RULE14: four-bit mode field sets count sequence
// RULE15: overflow flag set per mode, interrupts
// RULE16: top and zero marks signalled
// RULE17: zero is 0x0000, full is 0xffff
// RULE18: top is fixed, compare A or capture
// RULE19: unpaired high read returns holder value
`timescale 1ns/1ps
`default_nettype none
module t16ba_dev
  import t16ba_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  t16ba_if.dev bus,
  input wire logic i_external_count_pin,
  output logic [15:0] o_timer_count_value,
  output logic o_top_mark,
  output logic o_count_zero_mark,
  output logic o_overflow_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding, used by the count logic and the mark outputs
  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] ca,
                                         input logic [15:0] cap);
    case (m)
      4'h1, 4'h5: top_of = T16BA_TOP8;
      4'h2, 4'h6: top_of = T16BA_TOP9;
      4'h3, 4'h7: top_of = T16BA_TOP10;
      4'h4, 4'h9, 4'hb, 4'hf: top_of = ca;
      4'h8, 4'ha, 4'hc, 4'he: top_of = cap;
      default: top_of = T16BA_FULL;
    endcase
  endfunction

  function automatic logic is_dual(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: is_dual = 1'b1;
      default: is_dual = 1'b0;
    endcase
  endfunction

  function automatic logic ovf_at_top(input logic [3:0] m);
    case (m)
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: ovf_at_top = 1'b1;
      default: ovf_at_top = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [7:0] hold_q;
  logic [15:0] cnt_q, cnt_d;
  logic [15:0] cmpa_q, cmpb_q, cap_q;
  logic [7:0] ctrl_a_q, ctrl_b_q;
  logic ovf_q, ovf_d, mask_q;
  logic up_q, up_d;
  logic [9:0] pre_q;
  logic ext_s1_q, ext_s2_q, ext_s3_q;
  logic [7:0] rdata_q;
  logic irq_q, top_q, zero_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode of byte strobes
  wire wr_cnt_l = bus.wr && (bus.addr == T16BA_CNT_L);
  wire wr_cmpa_l = bus.wr && (bus.addr == T16BA_CMPA_L);
  wire wr_cmpb_l = bus.wr && (bus.addr == T16BA_CMPB_L);
  wire wr_cap_l = bus.wr && (bus.addr == T16BA_CAP_L);
  // Every high location on write goes to the one holder
  wire wr_any_h = bus.wr && (bus.addr == T16BA_CNT_H || bus.addr == T16BA_CMPA_H ||
                  bus.addr == T16BA_CMPB_H || bus.addr == T16BA_CAP_H); // [RULE2] [RULE10]
  wire rd_cnt_l = bus.rd && (bus.addr == T16BA_CNT_L);
  wire rd_cap_l = bus.rd && (bus.addr == T16BA_CAP_L);
  wire wr_flags = bus.wr && (bus.addr == T16BA_FLAGS);

  // Control fields
  wire [2:0] cs_w = ctrl_b_q[T16BA_CS_POS +: 3];
  wire [3:0] mode_w = {ctrl_b_q[T16BA_MODE_HI_POS +: 2], ctrl_a_q[T16BA_MODE_LO_POS +: 2]}; // [RULE14]
  wire [15:0] top_w = top_of(mode_w, cmpa_q, cap_q); // [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // Timer tick selection; the pin is only seen after two flops
  wire ext_rise = ext_s2_q && !ext_s3_q;
  wire ext_fall = !ext_s2_q && ext_s3_q;
  logic tick_w;
  always_comb begin
    case (cs_w) // [RULE9]
      T16BA_CS_STOP: tick_w = 1'b0;
      T16BA_CS_DIV1: tick_w = 1'b1;
      T16BA_CS_DIV8: tick_w = &pre_q[2:0];
      T16BA_CS_DIV64: tick_w = &pre_q[5:0];
      T16BA_CS_DIV256: tick_w = &pre_q[7:0];
      T16BA_CS_DIV1024: tick_w = &pre_q;
      T16BA_CS_EXT_FALL: tick_w = ext_fall;
      default: tick_w = ext_rise;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next count: slope, direction and overflow event
  wire at_top = (cnt_q == top_w);
  wire at_zero = (cnt_q == T16BA_ZERO); // [RULE17]
  logic tov_w;
  always_comb begin
    cnt_d = cnt_q;
    up_d = up_q;
    tov_w = 1'b0;
    if (tick_w) begin // [RULE11]
      if (is_dual(mode_w)) begin
        if (up_q && at_top) begin
          cnt_d = cnt_q - 16'h0001;
          up_d = 1'b0;
        end else if (!up_q && at_zero) begin
          cnt_d = cnt_q + 16'h0001;
          up_d = 1'b1;
          tov_w = 1'b1; // [RULE15]
        end else if (up_q) begin
          cnt_d = cnt_q + 16'h0001;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end else begin
        cnt_d = at_top ? T16BA_ZERO : cnt_q + 16'h0001;
        up_d = 1'b1;
        tov_w = ovf_at_top(mode_w) ? at_top : (cnt_q == T16BA_FULL); // [RULE15]
      end
    end
    // Host write wins over clear and count; a same-cycle tick still updates direction and the overflow event
    if (wr_cnt_l) begin // [RULE13] [RULE12]
      cnt_d = {hold_q, bus.wdata}; // [RULE3] [RULE1]
    end
  end

  // Overflow flag: a new event wins over a write-one clear
  always_comb begin
    ovf_d = ovf_q;
    if (wr_flags && bus.wdata[T16BA_OVF_POS]) begin
      ovf_d = 1'b0;
    end
    if (tov_w) begin
      ovf_d = 1'b1; // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  logic [7:0] rsel_w;
  always_comb begin
    case (bus.addr)
      T16BA_CNT_L: rsel_w = cnt_q[7:0];
      T16BA_CNT_H: rsel_w = hold_q; // [RULE10] [RULE19]
      T16BA_CMPA_L: rsel_w = cmpa_q[7:0];
      T16BA_CMPA_H: rsel_w = cmpa_q[15:8]; // [RULE5]
      T16BA_CMPB_L: rsel_w = cmpb_q[7:0];
      T16BA_CMPB_H: rsel_w = cmpb_q[15:8]; // [RULE5]
      T16BA_CAP_L: rsel_w = cap_q[7:0];
      T16BA_CAP_H: rsel_w = hold_q;
      T16BA_CTRL_A: rsel_w = ctrl_a_q;
      T16BA_CTRL_B: rsel_w = ctrl_b_q;
      T16BA_FLAGS: rsel_w = {7'h00, ovf_q};
      T16BA_MASK: rsel_w = {7'h00, mask_q};
      default: rsel_w = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holder: loaded by high writes and by low reads of counter or capture;
  // it keeps its value otherwise so a high byte may be reused
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_q <= T16BA_BYTE_RST;
    end else if (wr_any_h) begin
      hold_q <= bus.wdata; // [RULE8]
    end else if (rd_cnt_l) begin
      hold_q <= cnt_q[15:8]; // [RULE4]
    end else if (rd_cap_l) begin
      hold_q <= cap_q[15:8]; // [RULE4]
    end
  end

  // Sixteen-bit value registers, loaded whole on a low write
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cmpa_q <= T16BA_WORD_RST;
      cmpb_q <= T16BA_WORD_RST;
      cap_q <= T16BA_WORD_RST;
    end else begin
      if (wr_cmpa_l) cmpa_q <= {hold_q, bus.wdata}; // [RULE3]
      if (wr_cmpb_l) cmpb_q <= {hold_q, bus.wdata}; // [RULE3]
      if (wr_cap_l) cap_q <= {hold_q, bus.wdata}; // [RULE3]
    end
  end

  // Control bytes and interrupt mask
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_a_q <= T16BA_BYTE_RST;
      ctrl_b_q <= T16BA_BYTE_RST;
      mask_q <= 1'b0;
    end else if (bus.wr) begin
      if (bus.addr == T16BA_CTRL_A) ctrl_a_q <= bus.wdata;
      if (bus.addr == T16BA_CTRL_B) ctrl_b_q <= bus.wdata;
      if (bus.addr == T16BA_MASK) mask_q <= bus.wdata[T16BA_OVF_POS];
    end
  end

  // Counter core, prescaler and pin synchroniser
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= T16BA_WORD_RST;
      up_q <= 1'b1;
      ovf_q <= 1'b0;
      pre_q <= 10'h000;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      up_q <= up_d;
      ovf_q <= ovf_d;
      pre_q <= pre_q + 10'h001;
      ext_s1_q <= i_external_count_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // Registered answers and marks; marks follow the value being loaded
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= T16BA_BYTE_RST;
      irq_q <= 1'b0;
      top_q <= 1'b0;
      zero_q <= 1'b1;
    end else begin
      if (bus.rd) rdata_q <= rsel_w;
      irq_q <= ovf_d && mask_q; // [RULE15]
      top_q <= (cnt_d == top_w); // [RULE16]
      zero_q <= (cnt_d == T16BA_ZERO); // [RULE16] [RULE17]
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.irq = irq_q;
  assign o_timer_count_value = cnt_q;
  assign o_top_mark = top_q;
  assign o_count_zero_mark = zero_q;
  assign o_overflow_flag = ovf_q;

endmodule // t16ba_dev
`default_nettype wire

// ### core/t16ba_pkg.sv
// Shared constants for the 16-bit timer byte-access path and its controller
package t16ba_pkg;
  // Byte locations on the narrow device bus
  localparam logic [3:0] T16BA_CNT_L = 4'h0;
  localparam logic [3:0] T16BA_CNT_H = 4'h1;
  localparam logic [3:0] T16BA_CMPA_L = 4'h2;
  localparam logic [3:0] T16BA_CMPA_H = 4'h3;
  localparam logic [3:0] T16BA_CMPB_L = 4'h4;
  localparam logic [3:0] T16BA_CMPB_H = 4'h5;
  localparam logic [3:0] T16BA_CAP_L = 4'h6;
  localparam logic [3:0] T16BA_CAP_H = 4'h7;
  localparam logic [3:0] T16BA_CTRL_A = 4'h8;
  localparam logic [3:0] T16BA_CTRL_B = 4'h9;
  localparam logic [3:0] T16BA_FLAGS = 4'ha;
  localparam logic [3:0] T16BA_MASK = 4'hb;
  // Field positions inside the control bytes and the flag and mask bytes
  localparam int T16BA_MODE_LO_POS = 0;
  localparam int T16BA_CS_POS = 0;
  localparam int T16BA_MODE_HI_POS = 3;
  localparam int T16BA_OVF_POS = 0;
  // Fixed count limits
  localparam logic [15:0] T16BA_ZERO = 16'h0000;
  localparam logic [15:0] T16BA_FULL = 16'hffff;
  localparam logic [15:0] T16BA_TOP8 = 16'h00ff;
  localparam logic [15:0] T16BA_TOP9 = 16'h01ff;
  localparam logic [15:0] T16BA_TOP10 = 16'h03ff;
  // Values after reset
  localparam logic [7:0] T16BA_BYTE_RST = 8'h00;
  localparam logic [15:0] T16BA_WORD_RST = 16'h0000;
  // Clock source codes
  localparam logic [2:0] T16BA_CS_STOP = 3'h0;
  localparam logic [2:0] T16BA_CS_DIV1 = 3'h1;
  localparam logic [2:0] T16BA_CS_DIV8 = 3'h2;
  localparam logic [2:0] T16BA_CS_DIV64 = 3'h3;
  localparam logic [2:0] T16BA_CS_DIV256 = 3'h4;
  localparam logic [2:0] T16BA_CS_DIV1024 = 3'h5;
  localparam logic [2:0] T16BA_CS_EXT_FALL = 3'h6;
  // Avalon register byte offsets of the controller
  localparam logic [4:0] T16BA_AV_TARGET = 5'h00;
  localparam logic [4:0] T16BA_AV_WDATA = 5'h04;
  localparam logic [4:0] T16BA_AV_RDCMD = 5'h08;
  localparam logic [4:0] T16BA_AV_RDATA = 5'h0c;
  localparam logic [4:0] T16BA_AV_STATUS = 5'h10;
  localparam logic [4:0] T16BA_AV_IRQ_ST = 5'h14;
  localparam logic [4:0] T16BA_AV_IRQ_MASK = 5'h18;
  localparam logic [4:0] T16BA_AV_BYTE = 5'h1c;
  // Bits of the Avalon command words and of the interrupt status and mask registers
  localparam int T16BA_REUSE_POS = 16;
  localparam int T16BA_BYTE_RD_POS = 16;
  localparam int T16BA_IRQ_DONE = 0;
  localparam int T16BA_IRQ_DEV = 1;
endpackage

// ### core/t16ba_if.sv
// Narrow byte bus between the timer and its controlling party
`timescale 1ns/1ps
`default_nettype none
interface t16ba_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  modport dev (input addr, wdata, wr, rd, output rdata, irq);
  modport cpu (output addr, wdata, wr, rd, input rdata, irq);
endinterface
`default_nettype wire

// ### core/t16ba_host.sv
// Controller end: Avalon-MM slave that runs byte sequences on the timer bus
`timescale 1ns/1ps
`default_nettype none
module t16ba_host
  import t16ba_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  t16ba_if.cpu bus,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq
);

  typedef enum {S_IDLE, S_WR_HI, S_WR_LO, S_RD_LO, S_RD_HI, S_RD_END,
                S_BYTE, S_BYTE_WAIT, S_BYTE_END} t16ba_st_t;

  t16ba_st_t st_q;
  logic [3:0] tgt_q, baddr_q;
  logic [15:0] wval_q, rval_q;
  logic bwr_q, rpair_q;
  logic [3:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q, rd_q;
  logic [31:0] rdat_q;
  logic wait_q;
  logic [1:0] ist_q, ist_d, imask_q;
  logic irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode; commands stall on waitrequest while a sequence runs
  wire idle_w = (st_q == S_IDLE);
  wire is_cmd = (i_avs_address == T16BA_AV_WDATA) || (i_avs_address == T16BA_AV_RDCMD) ||
                (i_avs_address == T16BA_AV_BYTE);
  wire req_w = (i_avs_read || i_avs_write) && wait_q && (idle_w || !is_cmd);
  wire take_w = (i_avs_read || i_avs_write) && !wait_q;
  wire wtake_w = take_w && i_avs_write;
  wire rtake_w = take_w && i_avs_read;
  wire [3:0] lo_addr = {tgt_q[2:0], 1'b0};
  wire done_w = (st_q == S_RD_END) || (st_q == S_WR_LO) || (st_q == S_BYTE_END);

  // Readback selection of the controller registers
  logic [31:0] rsel_w;
  always_comb begin
    case (i_avs_address)
      T16BA_AV_TARGET: rsel_w = {28'h0000000, tgt_q};
      T16BA_AV_WDATA: rsel_w = {16'h0000, wval_q};
      T16BA_AV_RDATA: rsel_w = {16'h0000, rval_q};
      T16BA_AV_STATUS: rsel_w = {31'h00000000, !idle_w};
      T16BA_AV_IRQ_ST: rsel_w = {30'h00000000, ist_q};
      T16BA_AV_IRQ_MASK: rsel_w = {30'h00000000, imask_q};
      default: rsel_w = 32'h00000000;
    endcase
  end

  // Sticky events; a read clears them but a same-cycle event survives
  always_comb begin
    ist_d = ist_q;
    if (rtake_w && i_avs_address == T16BA_AV_IRQ_ST) ist_d = 2'b00;
    if (done_w) ist_d[T16BA_IRQ_DONE] = 1'b1;
    if (bus.irq) ist_d[T16BA_IRQ_DEV] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, answer at the following edge
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wait_q <= 1'b1;
      rdat_q <= 32'h00000000;
      tgt_q <= 4'h0;
      imask_q <= 2'b00;
      ist_q <= 2'b00;
      irq_q <= 1'b0;
    end else begin
      wait_q <= !req_w;
      if (req_w && i_avs_read) rdat_q <= rsel_w;
      if (wtake_w && i_avs_address == T16BA_AV_TARGET) tgt_q <= i_avs_writedata[3:0];
      if (wtake_w && i_avs_address == T16BA_AV_IRQ_MASK) imask_q <= i_avs_writedata[1:0];
      ist_q <= ist_d;
      irq_q <= |(ist_d & imask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencer; the pair is issued back to back and nothing else can
  // reach the holder between the two halves
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= S_IDLE;
      wval_q <= 16'h0000;
      rval_q <= 16'h0000;
      baddr_q <= 4'h0;
      bwr_q <= 1'b0;
      rpair_q <= 1'b0;
      addr_q <= 4'h0;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (wtake_w && i_avs_address == T16BA_AV_WDATA) begin
            wval_q <= i_avs_writedata[15:0];
            // Reuse skips the high byte, the holder keeps its value
            st_q <= i_avs_writedata[T16BA_REUSE_POS] ? S_WR_LO : S_WR_HI; // [RULE8]
          end else if (wtake_w && i_avs_address == T16BA_AV_RDCMD) begin
            rpair_q <= 1'b1;
            st_q <= S_RD_LO;
          end else if (wtake_w && i_avs_address == T16BA_AV_BYTE) begin
            rpair_q <= 1'b0;
            baddr_q <= i_avs_writedata[11:8];
            wdata_q <= i_avs_writedata[7:0];
            bwr_q <= !i_avs_writedata[T16BA_BYTE_RD_POS];
            st_q <= S_BYTE;
          end
        end
        S_WR_HI: begin
          addr_q <= lo_addr | 4'h1;
          wdata_q <= wval_q[15:8];
          wr_q <= 1'b1; // [RULE6] [RULE1]
          st_q <= S_WR_LO;
        end
        S_WR_LO: begin
          addr_q <= lo_addr;
          wdata_q <= wval_q[7:0];
          wr_q <= 1'b1; // [RULE6] [RULE7]
          st_q <= S_IDLE;
        end
        S_RD_LO: begin
          addr_q <= lo_addr;
          rd_q <= 1'b1; // [RULE6] [RULE1]
          st_q <= S_RD_HI;
        end
        S_RD_HI: begin
          addr_q <= lo_addr | 4'h1;
          rd_q <= 1'b1; // [RULE7]
          st_q <= S_RD_END;
        end
        S_RD_END: begin
          rval_q[7:0] <= bus.rdata;
          st_q <= S_BYTE_END;
          rd_q <= 1'b0;
        end
        S_BYTE: begin
          addr_q <= baddr_q;
          wr_q <= bwr_q;
          rd_q <= !bwr_q;
          // Read data stands one edge after the strobe, so a byte read waits
          st_q <= bwr_q ? S_BYTE_END : S_BYTE_WAIT;
        end
        S_BYTE_WAIT: begin
          st_q <= S_BYTE_END;
        end
        S_BYTE_END: begin
          // Pair read: high byte now on the bus; byte read shifts the old low up
          if (rpair_q) begin
            rval_q[15:8] <= bus.rdata;
          end else if (!bwr_q) begin
            rval_q <= {rval_q[7:0], bus.rdata};
          end
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign o_avs_readdata = rdat_q;
  assign o_avs_waitrequest = wait_q;
  assign o_irq = irq_q;

endmodule // t16ba_host
`default_nettype wire

// ### verification/t16ba_properties.sv
// Checker on the byte bus joining the timer and its controller
`timescale 1ns/1ps
`default_nettype none
module t16ba_properties
  import t16ba_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic [15:0] o_timer_count_value,
  input wire logic o_count_zero_mark,
  input wire logic o_overflow_flag
);
  ////////////////////////////////////////
  // Stop tracking; a tick already in flight may still land just after the stop write
  logic run_q;
  logic [1:0] age_q;
  wire logic cs_wr = wr && addr == T16BA_CTRL_B;
  wire logic frozen = !run_q && age_q == 2'h3;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      run_q <= 1'b0;
      age_q <= 2'h3;
    end else if (cs_wr) begin
      run_q <= wdata[T16BA_CS_POS +: 3] != T16BA_CS_STOP;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Two-byte counter accesses as the controller issues them
  sequence s_wr_pair;
    wr && addr == T16BA_CNT_H ##1 wr && addr == T16BA_CNT_L;
  endsequence
  sequence s_rd_pair;
    rd && addr == T16BA_CNT_L ##1 rd && addr == T16BA_CNT_H;
  endsequence
  AST_ONE_STROBE: assert property (
    !(rd && wr)) else $error("Read and write strobes together");
  AST_HIGH_FIRST: assert property (
    wr && addr[0] && !addr[3] |=> wr && addr == $past(addr) - 4'h1)
    else $error("High byte write without its low byte");
  AST_WORD_LOAD: assert property (
    s_wr_pair |=> o_timer_count_value == {$past(wdata, 2), $past(wdata)})
    else $error("Counter not loaded from both bytes");
  AST_READ_PAIR: assert property (
    s_rd_pair |-> rdata == $past(o_timer_count_value[7:0])
      ##1 rdata == $past(o_timer_count_value[15:8], 2))
    else $error("Counter read pair returned wrong bytes");
  AST_RDATA_HOLD: assert property (
    !rd |=> $stable(rdata)) else $error("Read data moved without a read");
  AST_ZERO_MARK: assert property (
    o_timer_count_value == T16BA_ZERO && $stable(o_timer_count_value) |-> o_count_zero_mark)
    else $error("Zero mark missing");
  AST_IRQ_CAUSE: assert property (
    !o_overflow_flag && !$past(o_overflow_flag) |-> !irq)
    else $error("Interrupt without overflow flag");
  AST_FROZEN: assert property (
    frozen && !(wr && addr == T16BA_CNT_L) |=> $stable(o_timer_count_value))
    else $error("Stopped counter moved");
endmodule // t16ba_properties
`default_nettype wire

// ### verification/tb_top.sv
// Bench joining the controller and timer ends over the byte bus
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import t16ba_pkg::*;
;
  ////////////////////////////////////////
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic ext_pin = 1'b0;
  logic [4:0] av_addr = 5'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata, last, v;
  logic [63:0] note;
  logic [63:0] notes[$];
  logic av_wait, host_irq, top_mark, zero_mark, ovf, ts;
  logic [15:0] cnt, a, mx;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 6447;
  t16ba_if t16ba_if_i ();
  t16ba_host t16ba_host_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(t16ba_if_i),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .o_irq(host_irq));
  t16ba_dev t16ba_dev_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .bus(t16ba_if_i),
    .i_external_count_pin(ext_pin), .o_timer_count_value(cnt), .o_top_mark(top_mark),
    .o_count_zero_mark(zero_mark), .o_overflow_flag(ovf));
  t16ba_properties t16ba_properties_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .addr(t16ba_if_i.addr), .wdata(t16ba_if_i.wdata), .wr(t16ba_if_i.wr), .rd(t16ba_if_i.rd),
    .rdata(t16ba_if_i.rdata), .irq(t16ba_if_i.irq), .o_timer_count_value(cnt),
    .o_count_zero_mark(zero_mark), .o_overflow_flag(ovf));
  initial forever #20 i_mclk = ~i_mclk;
  // Hang guard; the external pin toggles slowly enough for the two-flop sync
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles[1:0] == 2'h0) ext_pin <= ~ext_pin;
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end
  // Result watcher: polling reads carry no note, checked reads take the oldest
  always @(posedge i_mclk) begin
    if (av_rd && av_wait === 1'b0 && notes.size() != 0) begin
      note = notes.pop_front();
      check(av_rdata & note[63:32], note[31:0]);
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Avalon transfer held until the rising edge that sees waitrequest low;
  // data taken there, then released, and one edge passes before the next
  task automatic av(input logic [4:0] ad, input logic w, input logic [31:0] d);
    av_addr <= ad;
    av_wr <= w;
    av_rd <= !w;
    av_wdata <= d;
    @(posedge i_mclk);
    while (av_wait !== 1'b0) @(posedge i_mclk);
    last = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic cmd(input logic [4:0] ad, input logic [31:0] d);
    av(ad, 1'b1, d);
    do av(T16BA_AV_STATUS, 1'b0, 32'h0); while (last[0] !== 1'b0);
  endtask
  task automatic w16(input logic [3:0] t, input logic [31:0] d);
    cmd(T16BA_AV_TARGET, {28'h0, t});
    cmd(T16BA_AV_WDATA, d);
  endtask
  task automatic r16(input logic [3:0] t, input logic [15:0] e);
    cmd(T16BA_AV_TARGET, {28'h0, t});
    cmd(T16BA_AV_RDCMD, 32'h0);
    notes.push_back({32'h0000ffff, 16'h0, e});
    av(T16BA_AV_RDATA, 1'b0, 32'h0);
  endtask
  task automatic bwr(input logic [3:0] ad, input logic [7:0] d);
    cmd(T16BA_AV_BYTE, {20'h0, ad, d});
  endtask
  task automatic brd(input logic [3:0] ad, input logic [7:0] e);
    cmd(T16BA_AV_BYTE, {15'h0, 1'b1, 4'h0, ad, 8'h0});
    notes.push_back({32'h000000ff, 24'h0, e});
    av(T16BA_AV_RDATA, 1'b0, 32'h0);
  endtask
  task automatic set_mode(input logic [3:0] m, input logic [2:0] cs);
    bwr(T16BA_CTRL_A, {6'h0, m[1:0]});
    bwr(T16BA_CTRL_B, {3'h0, m[3:2], cs});
  endtask
  // Upper limit of each mode with compare A at 0x50 and capture at 0x40
  function automatic logic [15:0] top_of(input int m);
    case (m)
      1, 5: return T16BA_TOP8;
      2, 6: return T16BA_TOP9;
      3, 7: return T16BA_TOP10;
      4, 9, 11, 15: return 16'h0050;
      8, 10, 12, 14: return 16'h0040;
      default: return T16BA_FULL;
    endcase
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    @(posedge i_mclk);
    check(32'(cnt), 32'h0);
    check(32'(zero_mark), 32'h1);
    // Words written high first and read low first, timer stopped
    w16(4'h0, 32'h01ff);
    check(32'(cnt), 32'h01ff);
    for (int t = 0; t < 4; t++) begin
      v = $random(seed);
      w16(t[3:0], {16'h0, v[15:0]});
      r16(t[3:0], v[15:0]);
    end
    // One held high byte reused by a low-only write
    w16(4'h0, 32'habcd);
    w16(4'h1, 32'h10012);
    r16(4'h1, 16'hab12);
    // Holder filled by a counter read survives compare reads
    w16(4'h0, 32'h3456);
    r16(4'h0, 16'h3456);
    brd(T16BA_CMPA_L, 8'h12);
    brd(T16BA_CMPA_H, 8'hab);
    brd(T16BA_CNT_H, 8'h34);
    notes.push_back(64'hffffffff_00000000);
    av(5'h02, 1'b0, 32'h0);
    // Load while running, count rate, wrap, overflow and interrupt path
    set_mode(4'h0, T16BA_CS_DIV1);
    w16(4'h0, 32'hff00);
    @(negedge i_mclk);
    a = cnt;
    repeat (10) @(negedge i_mclk);
    check(32'(cnt), 32'(a + 16'd10));
    repeat (300) @(posedge i_mclk);
    check(32'(ovf), 32'h1);
    bwr(T16BA_MASK, 8'h01);
    cmd(T16BA_AV_IRQ_MASK, 32'h2);
    check(32'(t16ba_if_i.irq), 32'h1);
    check(32'(host_irq), 32'h1);
    notes.push_back(64'h2_00000002);
    av(T16BA_AV_IRQ_ST, 1'b0, 32'h0);
    cmd(T16BA_AV_IRQ_MASK, 32'h0);
    check(32'(host_irq), 32'h0);
    bwr(T16BA_FLAGS, 8'h01);
    check(32'(ovf), 32'h0);
    set_mode(4'h0, T16BA_CS_STOP);
    a = cnt;
    repeat (50) @(posedge i_mclk);
    check(32'(cnt), 32'(a));
    // Every clock source code other than stop moves the counter
    for (int c = 1; c < 8; c++) begin
      w16(4'h0, 32'h0);
      set_mode(4'h0, c[2:0]);
      repeat (1100) @(posedge i_mclk);
      set_mode(4'h0, T16BA_CS_STOP);
      check(32'(cnt != 16'h0), 32'h1);
    end
    // Count sequence, limits and overflow of modes 1 to 15, no upper limit check in mode 13
    w16(4'h1, 32'h0050);
    w16(4'h3, 32'h0040);
    for (int m = 1; m < 16; m++) begin
      set_mode(m[3:0], T16BA_CS_STOP);
      w16(4'h0, 32'h0);
      bwr(T16BA_FLAGS, 8'h01);
      set_mode(m[3:0], T16BA_CS_DIV1);
      mx = 16'h0;
      ts = 1'b0;
      repeat (2100) begin
        @(negedge i_mclk);
        if (cnt > mx) mx = cnt;
        if (top_mark === 1'b1) ts = 1'b1;
      end
      @(posedge i_mclk);
      if (m != 13) check(32'(mx), 32'(top_of(m)));
      check(32'(ts), 32'(m != 13));
      check(32'(ovf), 32'(!(m inside {4, 12, 13})));
    end
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
